// file: sram_port_ctrl.sv
/*
  Host controller that drives an asynchronous 1M x 4 static memory through its pins.
  Assumes requests are synchronous to sys_clk_i and the board resolves the data wires.
*/
// Overview of operation
// - Address is set before chip select goes low.
// - Address changes only while write enable or chip select is high.
// - Host never drives data while memory outputs are enabled.
// - Select and write enable overlap low for at least 10 ns.
// - Address settles no later than the write start; setup 0 ns.
// - Address holds until the write end; recovery 0 ns.
// - Write data stable at least 7 ns before write end.
// - Select is high before low-voltage retention; lead 0 ns.
`timescale 1ns/100ps
module sram_port_ctrl #(
  parameter int ADDR_WIDTH = 20,
  parameter int DATA_WIDTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Request port
  input wire logic req_valid_i,
  input wire logic req_write_i,
  input wire logic [ADDR_WIDTH-1:0] req_addr_i,
  input wire logic [DATA_WIDTH-1:0] req_wdata_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [DATA_WIDTH-1:0] rsp_rdata_o,
  // Retention handshake
  input wire logic retain_req_i,
  output logic retain_ok_o,
  // Memory pins
  output logic [ADDR_WIDTH-1:0] word_address_o,
  output logic chip_sel_n_o,
  output logic out_en_n_o,
  output logic write_en_n_o,
  output logic [DATA_WIDTH-1:0] data_pins_o,
  output logic data_pins_oe_o,
  input wire logic [DATA_WIDTH-1:0] data_pins_i
);
  import sram_port_pkg::*;

  // ***********************************************
  // State
  // ***********************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_WR_SETUP, ST_WR_PULSE, ST_WR_END,
    ST_RD_ACCESS, ST_RD_RELEASE, ST_RETAIN
  } state_t;

  state_t state_reg, state_next;
  logic [ADDR_WIDTH-1:0] addr_reg, addr_next;
  logic [DATA_WIDTH-1:0] wdata_reg, wdata_next;
  logic [DATA_WIDTH-1:0] rdata_reg, rdata_next;
  logic cs_n_reg, cs_n_next;
  logic oe_n_reg, oe_n_next;
  logic we_n_reg, we_n_next;
  logic doe_reg, doe_next;
  logic ready_reg, ready_next;
  logic rsp_reg, rsp_next;
  logic ret_reg, ret_next;

  // ***********************************************
  // Phase timer
  // ***********************************************
  // Done comes from the count alone, so a load
  // taken on done forms no combinational loop
  sram_timer_if tif ();

  sram_wait_timer u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .tmr(tif.tmr)
  );

  // ***********************************************
  // Sequencer
  // ***********************************************
  always_comb begin
    state_next = state_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    cs_n_next = cs_n_reg;
    oe_n_next = oe_n_reg;
    we_n_next = we_n_reg;
    doe_next = doe_reg;
    ready_next = ready_reg;
    rsp_next = 1'b0;
    ret_next = ret_reg;
    tif.load = 1'b0;
    tif.count = '0;
    unique case (state_reg)
      ST_IDLE: begin
        cs_n_next = 1'b1;
        oe_n_next = 1'b1;
        we_n_next = 1'b1;
        doe_next = 1'b0;
        if (retain_req_i) begin
          ready_next = 1'b0;
          tif.load = 1'b1;
          tif.count = CNT_W'(RETENTION_LEAD_CYC);
          state_next = ST_RETAIN;
        end else if (req_valid_i && ready_reg) begin
          addr_next = req_addr_i;
          ready_next = 1'b0;
          if (req_write_i) begin
            wdata_next = req_wdata_i;
            doe_next = 1'b1;
            we_n_next = 1'b0;
            state_next = ST_WR_SETUP;
          end else begin
            state_next = ST_RD_ACCESS;
          end
        end else begin
          ready_next = 1'b1;
        end
      end
      ST_WR_SETUP: begin
        cs_n_next = 1'b0;
        tif.load = 1'b1;
        tif.count = CNT_W'((WRITE_PULSE_CYC > DATA_SETUP_CYC) ? WRITE_PULSE_CYC : DATA_SETUP_CYC);
        state_next = ST_WR_PULSE;
      end
      ST_WR_PULSE: begin
        if (tif.done) begin
          we_n_next = 1'b1;
          cs_n_next = 1'b1;
          state_next = ST_WR_END;
        end
      end
      ST_WR_END: begin
        doe_next = 1'b0;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
      ST_RD_ACCESS: begin
        if (cs_n_reg) begin
          cs_n_next = 1'b0;
          oe_n_next = 1'b0;
          tif.load = 1'b1;
          tif.count = CNT_W'(READ_ACCESS_CYC);
        end else if (tif.done) begin
          rdata_next = data_pins_i;
          rsp_next = 1'b1;
          cs_n_next = 1'b1;
          oe_n_next = 1'b1;
          tif.load = 1'b1;
          tif.count = CNT_W'(RELEASE_CYC);
          state_next = ST_RD_RELEASE;
        end
      end
      ST_RD_RELEASE: begin
        if (tif.done) begin
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        cs_n_next = 1'b1;
        if (tif.done) begin
          ret_next = retain_req_i;
          if (!retain_req_i) begin
            ret_next = 1'b0;
            ready_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_reg <= ST_IDLE;
      addr_reg <= '0;
      wdata_reg <= '0;
      rdata_reg <= '0;
      cs_n_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      we_n_reg <= 1'b1;
      doe_reg <= 1'b0;
      ready_reg <= 1'b0;
      rsp_reg <= 1'b0;
      ret_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      cs_n_reg <= cs_n_next;
      oe_n_reg <= oe_n_next;
      we_n_reg <= we_n_next;
      doe_reg <= doe_next;
      ready_reg <= ready_next;
      rsp_reg <= rsp_next;
      ret_reg <= ret_next;
    end
  end

  // ***********************************************
  // Outputs
  // ***********************************************
  // Pins come straight from registers, free of glitches
  assign word_address_o = addr_reg;
  assign chip_sel_n_o = cs_n_reg;
  assign out_en_n_o = oe_n_reg;
  assign write_en_n_o = we_n_reg;
  assign data_pins_o = wdata_reg;
  assign data_pins_oe_o = doe_reg;
  assign req_ready_o = ready_reg;
  assign rsp_valid_o = rsp_reg;
  assign rsp_rdata_o = rdata_reg;
  assign retain_ok_o = ret_reg;
endmodule

// file: sram_port_pkg.sv
/*
  Shared constants for the host-side asynchronous static memory port controller.
  Assumes a single 200 MHz system clock; all times are in nanoseconds.
*/
package sram_port_pkg;

  // ***********************************************
  // Geometry
  // ***********************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 4;

  // ***********************************************
  // Timing
  // ***********************************************
  localparam int CLK_PERIOD_NS = 5;
  localparam int WRITE_PULSE_MIN_NS = 10;
  localparam int ADDR_SETUP_MIN_NS = 0;
  localparam int WRITE_RECOVERY_MIN_NS = 0;
  localparam int DATA_TO_WRITE_END_MIN_NS = 7;
  localparam int SELECT_ACCESS_MAX_NS = 15;
  localparam int OUTPUT_ENABLE_ACCESS_MAX_NS = 7;
  localparam int DESELECT_TO_RETENTION_MIN_NS = 0;
  localparam int OUTPUT_RELEASE_MAX_NS = 7;

  // Least times round up, never below one cycle
  localparam int WRITE_PULSE_CYC =
    ((WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (WRITE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DATA_SETUP_CYC =
    ((DATA_TO_WRITE_END_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
    (DATA_TO_WRITE_END_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Access waits are also waits the host must cover, so round up
  localparam int READ_ACCESS_CYC =
    (SELECT_ACCESS_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
  localparam int RELEASE_CYC =
    (OUTPUT_RELEASE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETENTION_LEAD_CYC = 1;
  localparam int CNT_W = 4;

endpackage

// file: sram_timer_if.sv
/*
  Carrier between the port sequencer and its wait timer.
  Assumes both ends share the system clock.
*/
`timescale 1ns/100ps
interface sram_timer_if;
  logic load;
  logic [3:0] count;
  logic done;
  modport seq (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface

// file: sram_wait_timer.sv
/*
  Down counter that times the write pulse, the read access and release, and the retention lead.
  Assumes load is a one-cycle pulse from the sequencer.
*/
`timescale 1ns/100ps
module sram_wait_timer (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Sequencer side
  sram_timer_if.tmr tmr
);
  import sram_port_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (tmr.load) begin
      cnt_next = tmr.count;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Done reads the count only; the sequencer loads on done
  assign tmr.done = (cnt_reg == '0);
endmodule

// file: sram_port_checker_assertions.sv
/* Pin protocol checks for the memory port controller.
   Bound to sram_port_ctrl and sees its ports only. */
`timescale 1ns/100ps
module sram_port_checker #(
  parameter int ADDR_WIDTH = 20,
  parameter int DATA_WIDTH = 4
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic req_ready_o,
  input wire logic rsp_valid_o,
  input wire logic retain_ok_o,
  input wire logic [ADDR_WIDTH-1:0] word_address_o,
  input wire logic chip_sel_n_o,
  input wire logic out_en_n_o,
  input wire logic write_en_n_o,
  input wire logic [DATA_WIDTH-1:0] data_pins_o,
  input wire logic data_pins_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_idle_quiet: assert property (req_ready_o |-> chip_sel_n_o && write_en_n_o && out_en_n_o && !data_pins_oe_o)
    else $error("strobe active while idle");
  a_addr_first: assert property ($fell(chip_sel_n_o) |-> $stable(word_address_o))
    else $error("address moved as select fell");
  a_addr_hold: assert property ($changed(word_address_o) |-> $past(chip_sel_n_o) || $past(write_en_n_o))
    else $error("address moved inside write");
  a_no_clash: assert property (!chip_sel_n_o && !out_en_n_o |-> !data_pins_oe_o)
    else $error("host drives during read");
  a_write_overlap: assert property ($rose(!chip_sel_n_o && !write_en_n_o) |-> (!chip_sel_n_o && !write_en_n_o)[*2])
    else $error("write overlap short");
  a_data_setup: assert property (!chip_sel_n_o && !write_en_n_o |-> data_pins_oe_o && $stable(data_pins_o))
    else $error("write data unstable");
  a_write_oe_off: assert property (!write_en_n_o |-> out_en_n_o)
    else $error("output enable low in write");
  a_read_wait: assert property (rsp_valid_o |-> !$past(out_en_n_o) && !$past(out_en_n_o, 3))
    else $error("read sampled too early");
  a_read_answer: assert property ($fell(out_en_n_o) |-> ##[3:5] rsp_valid_o)
    else $error("read answer late");
  a_retain_desel: assert property (retain_ok_o |-> chip_sel_n_o && $past(chip_sel_n_o))
    else $error("retention with select low");
endmodule
bind sram_port_ctrl sram_port_checker #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) chk (.sys_clk_i,
  .reset_n_i, .req_ready_o, .rsp_valid_o, .retain_ok_o, .word_address_o, .chip_sel_n_o, .out_en_n_o,
  .write_en_n_o, .data_pins_o, .data_pins_oe_o);

// file: sram_mem_model.sv
/* Behavioural 1M x 4 asynchronous memory; also resolves the data wires.
   Assumes no pulls on the data wires. */
`timescale 1ns/100ps
module sram_mem_model
  import sram_port_pkg::*;
#(
  // Select and output enable fall together, so select access governs
  parameter int ACC_NS = SELECT_ACCESS_MAX_NS
) (
  input wire logic [19:0] addr_i,
  input wire logic cs_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [3:0] host_d_i,
  input wire logic host_oe_i,
  output logic [3:0] bus_o
);
  logic [3:0] mem [int];
  wire rd = !cs_n_i && !oe_n_i && we_n_i;
  wire wr = !cs_n_i && !we_n_i;
  initial bus_o = 4'h0;
  // Store as the overlap ends, also when both strobes rise together
  always @(negedge wr) begin
    if (!$isunknown(addr_i)) mem[addr_i] = bus_o;
  end
  // Released wires show the inverse of the last level
  always @(host_d_i, host_oe_i, rd, addr_i) begin
    if (host_oe_i) bus_o = host_d_i;
    else begin
      bus_o = ~bus_o;
      if (rd) bus_o <= #(ACC_NS) (mem.exists(addr_i) ? mem[addr_i] : 4'h0);
    end
  end
endmodule

// file: async_sram_4bit_port_tb_top.sv
/* Self-checking bench for sram_port_ctrl with a memory model.
   Assumes a 200 MHz clock; inputs change 1 ns after the rising edge. */
`timescale 1ns/100ps
module async_sram_4bit_port_tb_top;
  import sram_port_pkg::*;
  logic sys_clk_i = 0, reset_n_i = 0, req_valid_i = 0, req_write_i = 0, retain_req_i = 0;
  logic [19:0] req_addr_i = '0, word_address_o;
  logic [3:0] req_wdata_i = '0, rsp_rdata_o, data_pins_o, data_pins_i;
  logic req_ready_o, rsp_valid_o, retain_ok_o, chip_sel_n_o, out_en_n_o, write_en_n_o, data_pins_oe_o;
  int miscompares = 0, n_tests = 0, seed = 32'hcfe4, k;
  logic [3:0] ref_mem [int];
  logic [19:0] pool [8];
  initial forever #2.5 sys_clk_i = ~sys_clk_i;
  sram_port_ctrl uut (.sys_clk_i, .reset_n_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i,
    .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .retain_req_i, .retain_ok_o, .word_address_o, .chip_sel_n_o,
    .out_en_n_o, .write_en_n_o, .data_pins_o, .data_pins_oe_o, .data_pins_i);
  sram_mem_model mem (.addr_i(word_address_o), .cs_n_i(chip_sel_n_o), .oe_n_i(out_en_n_o),
    .we_n_i(write_en_n_o), .host_d_i(data_pins_o), .host_oe_i(data_pins_oe_o), .bus_o(data_pins_i));
  task check(input logic [19:0] seen, input logic [19:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task conclude;
    if (miscompares == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic [3:0] expect_rd(input logic [19:0] a);
    return ref_mem[a];
  endfunction
  task automatic xfer(input logic w, input logic [19:0] a, input logic [3:0] d);
    int i;
    req_valid_i = 1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    i = 0;
    while (req_ready_o !== 1'b1 && i < 50) begin @(posedge sys_clk_i); #1; i++; end
    @(posedge sys_clk_i); #1;
    req_valid_i = 0;
    if (w) ref_mem[a] = d;
    else begin
      while (rsp_valid_o !== 1'b1 && i < 50) begin @(posedge sys_clk_i); #1; i++; end
      check(20'(rsp_rdata_o), 20'(expect_rd(a)), "read data");
    end
    check(20'(i < 50), 20'h1, "handshake");
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_i);
    #1 reset_n_i = 1;
    for (k = 0; k < 8; k++) begin
      pool[k] = (k == 0) ? 20'h00000 : (k == 1) ? 20'hFFFFF : 20'($random(seed));
      xfer(1, pool[k], 4'($random(seed)));
    end
    repeat (80) xfer($random(seed) % 2 == 0, pool[$unsigned($random(seed)) % 8], 4'($random(seed)));
    // Retention wins over a pending write
    xfer(0, pool[2], 4'h0);
    retain_req_i = 1;
    req_valid_i = 1;
    req_write_i = 1;
    req_addr_i = pool[2];
    req_wdata_i = ~expect_rd(pool[2]);
    repeat (8) @(posedge sys_clk_i);
    #1;
    check(20'(retain_ok_o), 20'h1, "retain ok");
    check(20'(chip_sel_n_o), 20'h1, "select in retention");
    check(20'(req_ready_o), 20'h0, "ready in retention");
    req_valid_i = 0;
    retain_req_i = 0;
    @(posedge sys_clk_i);
    #1;
    xfer(0, pool[2], 4'h0);
    // Reset in mid-run keeps strobes high
    reset_n_i = 0;
    @(posedge sys_clk_i); #1;
    check(20'({chip_sel_n_o, write_en_n_o, out_en_n_o, data_pins_oe_o}), 20'hE, "pins in reset");
    reset_n_i = 1;
    xfer(0, pool[1], 4'h0);
    conclude;
  end
  initial begin
    #40000;
    miscompares++;
    conclude;
  end
endmodule
